// ### design/uart_ext_regs.sv
// Banked register access for one channel of the dual serial controller
// Behaviour
// - Divisor bank: offset 0 is divisor low
// - Divisor bank: offset 1 is divisor high
// - Feature bank: 6 stop one, 4 resume one
// - Feature bank: 7 stop two, 5 resume two
// - Feature bank: offset 2 is feature register
// - Modem control at 4; bit 6 selects extended
// - Extended write at 6 loads threshold only while enhanced functions are on
// - Extended write at 7 loads trigger levels only while enhanced functions are on
// - Extended read at 7 returns ready status
// - Clearing modem bit 7 selects divide-by-one
// - Setting modem bit 7 selects divide-by-four
// - Line control reads back last written value
// - Decode uses address plus bank bits
// - Enhanced enable clear blocks upper modem bits
// - Ready status needs select, enable, no loop-back
`timescale 1ns/1ps
`include "uart_bank_defs.svh"

module uart_ext_regs (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic chip_select_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] fifo_ready_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic base_wr_out,
  output logic base_rd_out,
  output logic [2:0] base_addr_out,
  output logic [7:0] base_wdata_out,
  output logic [7:0] modem_out,
  output uart_bank_pkg::bank_config_type config_out
);
  import uart_bank_pkg::*;

  host_access_type acc;
  bank_type bank;
  logic [7:0] line_r;
  logic [7:0] modem_r;
  logic [7:0] modem_nxt;
  bank_config_type cfg_r;
  logic enh;
  logic wr_go;
  logic rd_go;
  logic [7:0] rd_nxt;
  logic base_hit;

  assign acc = '{addr: addr_in, data: wdata_in, wr: wr_in, rd: rd_in};
  assign enh = cfg_r.feature[`FEATURE_ENH_BIT];
  assign wr_go = clk_en_in && chip_select_in && acc.wr;
  assign rd_go = clk_en_in && chip_select_in && acc.rd;

  // ----------------------------------------
  // Bank decode
  // ----------------------------------------
  bank_select u_bank (
    .line_in(line_r),
    .ext_in(modem_r[`MODEM_EXT_BIT]),
    .bank_out(bank)
  );

  // ----------------------------------------
  // Line control
  // ----------------------------------------
  // Reachable in every bank, so the host can always leave a bank
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      line_r <= `RESET_LINE;
    end else if (wr_go && acc.addr == `OFS_LINE) begin
      line_r <= acc.data;
    end
  end

  // ----------------------------------------
  // Modem control
  // ----------------------------------------
  // Upper bits hold their value unless enhanced functions are on
  always_comb begin
    modem_nxt = enh ? acc.data
      : ((modem_r & `MODEM_LOCKED_MASK) | (acc.data & ~`MODEM_LOCKED_MASK));
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      modem_r <= `RESET_BYTE;
    end else if (wr_go && acc.addr == `OFS_MODEM && (bank == BANK_BASE || bank == BANK_EXTENDED)) begin
      modem_r <= modem_nxt;
    end
  end

  // ----------------------------------------
  // Banked configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_r <= '0;
    end else if (wr_go) begin
      case (bank)
        BANK_DIVISOR: begin
          if (acc.addr == `OFS_DIV_LOW) cfg_r.div_low <= acc.data;
          if (acc.addr == `OFS_DIV_HIGH) cfg_r.div_high <= acc.data;
        end
        BANK_FEATURE: begin
          if (acc.addr == `OFS_FEATURE) cfg_r.feature <= acc.data;
          if (acc.addr == `OFS_STOP_ONE) cfg_r.stop_one <= acc.data;
          if (acc.addr == `OFS_RESUME_ONE) cfg_r.resume_one <= acc.data;
          if (acc.addr == `OFS_STOP_TWO) cfg_r.stop_two <= acc.data;
          if (acc.addr == `OFS_RESUME_TWO) cfg_r.resume_two <= acc.data;
        end
        BANK_EXTENDED: begin
          // Still reached after enhanced functions are turned off, so each write checks them
          if (enh && acc.addr == `OFS_THRESHOLD) cfg_r.threshold <= acc.data;
          if (enh && acc.addr == `OFS_TRIGGER) cfg_r.trigger <= acc.data;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd_nxt = `RESET_BYTE;
    base_hit = 1'b0;
    if (acc.addr == `OFS_LINE) begin
      rd_nxt = line_r;
    end else begin
      case (bank)
        BANK_DIVISOR: begin
          if (acc.addr == `OFS_DIV_LOW) rd_nxt = cfg_r.div_low;
          else if (acc.addr == `OFS_DIV_HIGH) rd_nxt = cfg_r.div_high;
          else base_hit = 1'b1;
        end
        BANK_FEATURE: begin
          case (acc.addr)
            `OFS_FEATURE: rd_nxt = cfg_r.feature;
            `OFS_RESUME_ONE: rd_nxt = cfg_r.resume_one;
            `OFS_RESUME_TWO: rd_nxt = cfg_r.resume_two;
            `OFS_STOP_ONE: rd_nxt = cfg_r.stop_one;
            `OFS_STOP_TWO: rd_nxt = cfg_r.stop_two;
            default: base_hit = 1'b1;
          endcase
        end
        BANK_EXTENDED: begin
          if (acc.addr == `OFS_MODEM) rd_nxt = modem_r;
          else if (acc.addr == `OFS_THRESHOLD) rd_nxt = cfg_r.threshold;
          else if (acc.addr == `OFS_READY) begin
            // Ready status wins over trigger levels when its gate is open
            // Gate open only with the ready enable set and loop-back off
            if (!modem_r[`MODEM_READY_BIT] || modem_r[`MODEM_LOOP_BIT]) begin
              rd_nxt = cfg_r.trigger;
            end else begin
              rd_nxt = fifo_ready_in & `READY_USED_MASK;
            end
          end else base_hit = 1'b1;
        end
        default: begin
          if (acc.addr == `OFS_MODEM) rd_nxt = modem_r;
          else base_hit = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= `RESET_BYTE;
      rvalid_out <= 1'b0;
    end else if (clk_en_in) begin
      rvalid_out <= rd_go && !base_hit;
      if (rd_go && !base_hit) rdata_out <= rd_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      base_wr_out <= 1'b0;
      base_rd_out <= 1'b0;
      base_addr_out <= 3'h0;
      base_wdata_out <= `RESET_BYTE;
    end else if (clk_en_in) begin
      base_wr_out <= wr_go && base_hit && acc.addr != `OFS_MODEM;
      base_rd_out <= rd_go && base_hit;
      base_addr_out <= acc.addr;
      base_wdata_out <= acc.data;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      modem_out <= `RESET_BYTE;
      config_out <= '0;
    end else if (clk_en_in) begin
      modem_out <= modem_r;
      config_out <= cfg_r;
      config_out.prescale_four <= enh ? modem_r[`MODEM_PRESCALE_BIT] : config_out.prescale_four;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_ext_trigger_write;
    wr_go && bank == BANK_EXTENDED && enh && acc.addr == `OFS_TRIGGER;
  endsequence

  a_divisor_low_load: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_go && line_r == `LINE_DIVISOR_BANK && acc.addr == `OFS_DIV_LOW |=> cfg_r.div_low == $past(acc.data))
    else $error("divisor low not loaded");
  a_divisor_high_load: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_go && line_r == `LINE_DIVISOR_BANK && acc.addr == `OFS_DIV_HIGH |=> cfg_r.div_high == $past(acc.data))
    else $error("divisor high not loaded");
  a_stop_one_load: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_go && line_r == `LINE_FEATURE_BANK && acc.addr == `OFS_STOP_ONE |=> cfg_r.stop_one == $past(acc.data))
    else $error("stop one not loaded");
  a_resume_two_load: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_go && line_r == `LINE_FEATURE_BANK && acc.addr == `OFS_RESUME_TWO |=> cfg_r.resume_two == $past(acc.data))
    else $error("resume two not loaded");
  a_feature_load: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_go && line_r == `LINE_FEATURE_BANK && acc.addr == `OFS_FEATURE |=> cfg_r.feature == $past(acc.data))
    else $error("feature register not loaded");
  a_threshold_load: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_go && bank == BANK_EXTENDED && enh && acc.addr == `OFS_THRESHOLD |=> cfg_r.threshold == $past(acc.data))
    else $error("threshold not loaded");
  a_trigger_load: assert property (@(posedge clk_in) disable iff (reset_in)
    s_ext_trigger_write |=> cfg_r.trigger == $past(acc.data) ##1 config_out.trigger == $past(acc.data, 2))
    else $error("trigger levels not loaded");
  a_line_readback: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_go && acc.addr == `OFS_LINE |=> rvalid_out && rdata_out == $past(line_r))
    else $error("line control readback wrong");
  a_modem_lock: assert property (@(posedge clk_in) disable iff (reset_in)
    !enh && clk_en_in |=> modem_r[7:5] == $past(modem_r[7:5]))
    else $error("locked modem bits changed");
  a_ready_read: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_go && bank == BANK_EXTENDED && acc.addr == `OFS_READY && modem_r[`MODEM_READY_BIT]
      && !modem_r[`MODEM_LOOP_BIT] |=> rdata_out == ($past(fifo_ready_in) & `READY_USED_MASK))
    else $error("ready status not returned");
  a_prescale_follow: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && enh |=> config_out.prescale_four == $past(modem_r[`MODEM_PRESCALE_BIT]))
    else $error("prescaler select wrong");
  a_base_pass: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_go && bank == BANK_BASE && acc.addr != `OFS_LINE && acc.addr != `OFS_MODEM |=> base_rd_out && !rvalid_out)
    else $error("base read not passed on");
  a_modem_write: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_go && enh && bank == BANK_BASE && acc.addr == `OFS_MODEM |=> modem_r == $past(acc.data))
    else $error("modem control not loaded");
endmodule // uart_ext_regs

// ### design/uart_bank_defs.svh
// Offsets, field positions, bank codes and reset values of the banked register map
`ifndef UART_BANK_DEFS_SVH
`define UART_BANK_DEFS_SVH

`define OFS_DIV_LOW 3'h0
`define OFS_DIV_HIGH 3'h1
`define OFS_FEATURE 3'h2
`define OFS_LINE 3'h3
`define OFS_MODEM 3'h4
`define OFS_RESUME_ONE 3'h4
`define OFS_RESUME_TWO 3'h5
`define OFS_STOP_ONE 3'h6
`define OFS_THRESHOLD 3'h6
`define OFS_STOP_TWO 3'h7
`define OFS_TRIGGER 3'h7
`define OFS_READY 3'h7

`define LINE_DIVISOR_BANK 8'h80
`define LINE_FEATURE_BANK 8'hbf
`define LINE_BASE_BANK 8'h00

`define FEATURE_ENH_BIT 4
`define MODEM_READY_BIT 2
`define MODEM_LOOP_BIT 4
`define MODEM_EXT_BIT 6
`define MODEM_PRESCALE_BIT 7
`define MODEM_LOCKED_MASK 8'he0
`define READY_USED_MASK 8'h33

`define RESET_BYTE 8'h00
`define RESET_LINE 8'h1d
`endif

// ### design/uart_bank_pkg.sv
// Types shared by the banked register access logic
package uart_bank_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
    logic wr;
    logic rd;
  } host_access_type;

  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] feature;
    logic [7:0] stop_one;
    logic [7:0] stop_two;
    logic [7:0] resume_one;
    logic [7:0] resume_two;
    logic [7:0] threshold;
    logic [7:0] trigger;
    logic prescale_four;
  } bank_config_type;

  typedef enum logic [3:0] {
    BANK_BASE = 4'b0001,
    BANK_DIVISOR = 4'b0010,
    BANK_FEATURE = 4'b0100,
    BANK_EXTENDED = 4'b1000
  } bank_type;
endpackage

// ### design/bank_select.sv
// Bank decode from the line control value and the modem control extension bit
`timescale 1ns/1ps
`include "uart_bank_defs.svh"

module bank_select (
  input wire logic [7:0] line_in,
  input wire logic ext_in,
  output uart_bank_pkg::bank_type bank_out
);
  import uart_bank_pkg::*;

  always_comb begin
    if (line_in == `LINE_DIVISOR_BANK) begin
      bank_out = BANK_DIVISOR;
    end else if (line_in == `LINE_FEATURE_BANK) begin
      bank_out = BANK_FEATURE;
    end else if (ext_in) begin
      bank_out = BANK_EXTENDED;
    end else begin
      bank_out = BANK_BASE;
    end
  end
endmodule // bank_select

// ### tb/host_bus_model.sv
// Host processor model: register reads, writes and bank switching sequences
`timescale 1ns/1ps

module host_bus_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic chip_select_out,
  output logic [2:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  logic [7:0] saved_line;
  logic [7:0] saved_feature;

  initial begin
    chip_select_out = 1'b0;
    addr_out = 3'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Released bus carries inverted values so stale data never looks valid
  task automatic access(input logic is_wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    @(posedge clk_in);
    chip_select_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    wr_out <= is_wr;
    rd_out <= ~is_wr;
    @(posedge clk_in);
    chip_select_out <= 1'b0;
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    #1;
    ok = is_wr | rvalid_in;
    q = rdata_in;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    access(1'b1, a, d, q, ok);
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] q, output logic ok);
    access(1'b0, a, 8'h00, q, ok);
  endtask

  // ----------------------------------------
  // Host sequences
  // ----------------------------------------
  task automatic enable_ext;
    logic ok;
    rd_reg(3'h3, saved_line, ok);
    wr_reg(3'h3, 8'hbf);
    rd_reg(3'h2, saved_feature, ok);
    wr_reg(3'h2, saved_feature | 8'h10);
    wr_reg(3'h3, 8'h00);
  endtask

  task automatic restore_ext;
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h2, saved_feature);
    wr_reg(3'h3, saved_line);
  endtask

  task automatic ready_read(input logic [7:0] modem, output logic [7:0] q, output logic ok);
    wr_reg(3'h4, (modem & 8'hef) | 8'h40);
    rd_reg(3'h7, q, ok);
    wr_reg(3'h4, modem);
  endtask
endmodule // host_bus_model

// ### tb/uart_ext_regs_tb.sv
// Self-checking bench for the banked register access block
`timescale 1ns/1ps
`include "uart_bank_defs.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; $display("wrong value %s exp %h got %h", nm, exp, got); end end

module uart_ext_regs_tb;
  import uart_bank_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [7:0] fifo_ready_in = 8'hff;
  logic cs, wr, rd, rvalid, bwr, brd, ok;
  logic [2:0] addr, baddr;
  logic [7:0] wdata, rdata, bwdata, modem, q;
  bank_config_type cfg;
  int bad_count = 0;
  int cmp_count = 0;
  logic [2:0] ofs [5] = '{3'h6, 3'h4, 3'h7, 3'h5, 3'h2};
  logic [7:0] val [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h0f};

  always #50 clk_in = ~clk_in;

  uart_ext_regs i_uart_ext_regs (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .chip_select_in(cs), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .fifo_ready_in(fifo_ready_in), .rdata_out(rdata), .rvalid_out(rvalid), .base_wr_out(bwr),
    .base_rd_out(brd), .base_addr_out(baddr), .base_wdata_out(bwdata), .modem_out(modem),
    .config_out(cfg));
  host_bus_model i_host_bus_model (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .chip_select_out(cs), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e);
    i_host_bus_model.rd_reg(a, q, ok);
    `CHK("read answered", 1'b1, ok)
    `CHK(nm, e, q)
  endtask

  // Outputs toward the core lag the registers by one cycle
  task automatic settle;
    @(posedge clk_in);
    #1;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    bad_count++;
    conclude();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    rd_chk("line reset", `OFS_LINE, `RESET_LINE);
    i_host_bus_model.wr_reg(`OFS_LINE, `LINE_BASE_BANK);
    i_host_bus_model.wr_reg(`OFS_STOP_ONE, 8'h5a);
    `CHK("base forward", 4'he, {bwr, baddr})
    `CHK("base data", 8'h5a, bwdata)
    i_host_bus_model.rd_reg(`OFS_DIV_LOW, q, ok);
    `CHK("base read not answered", 1'b0, ok)
    `CHK("base read forward", 4'h8, {brd, baddr})
    i_host_bus_model.wr_reg(`OFS_MODEM, 8'he5);
    settle();
    `CHK("modem locked", 8'h05, modem)
    i_host_bus_model.wr_reg(`OFS_LINE, `LINE_DIVISOR_BANK);
    i_host_bus_model.wr_reg(`OFS_DIV_LOW, 8'h12);
    i_host_bus_model.wr_reg(`OFS_DIV_HIGH, 8'h34);
    settle();
    `CHK("div low", 8'h12, cfg.div_low)
    `CHK("div high", 8'h34, cfg.div_high)
    rd_chk("div low rd", `OFS_DIV_LOW, 8'h12);
    rd_chk("div high rd", `OFS_DIV_HIGH, 8'h34);
    rd_chk("line rd", `OFS_LINE, 8'h80);
    clk_en_in <= 1'b0;
    i_host_bus_model.wr_reg(`OFS_LINE, 8'h55);
    clk_en_in <= 1'b1;
    rd_chk("line frozen", `OFS_LINE, 8'h80);
    i_host_bus_model.wr_reg(`OFS_LINE, `LINE_FEATURE_BANK);
    for (int i = 0; i < 5; i++) begin
      i_host_bus_model.wr_reg(ofs[i], val[i]);
    end
    settle();
    `CHK("stop one", 8'h11, cfg.stop_one)
    `CHK("resume one", 8'h22, cfg.resume_one)
    `CHK("stop two", 8'h33, cfg.stop_two)
    `CHK("resume two", 8'h44, cfg.resume_two)
    `CHK("feature", 8'h0f, cfg.feature)
    i_host_bus_model.wr_reg(`OFS_LINE, `LINE_BASE_BANK);
    i_host_bus_model.enable_ext();
    i_host_bus_model.wr_reg(`OFS_MODEM, 8'h40);
    i_host_bus_model.wr_reg(`OFS_THRESHOLD, 8'h3c);
    i_host_bus_model.wr_reg(`OFS_TRIGGER, 8'h21);
    settle();
    `CHK("modem ext", 8'h40, modem)
    `CHK("threshold", 8'h3c, cfg.threshold)
    `CHK("trigger", 8'h21, cfg.trigger)
    i_host_bus_model.ready_read(8'h44, q, ok);
    `CHK("ready ok", 1'b1, ok)
    `CHK("ready", 8'h33, q)
    fifo_ready_in <= 8'h5a;
    i_host_bus_model.ready_read(8'h54, q, ok);
    `CHK("ready live", 8'h12, q)
    settle();
    `CHK("modem restored", 8'h54, modem)
    rd_chk("ready loop gated", `OFS_READY, 8'h21);
    i_host_bus_model.wr_reg(`OFS_MODEM, 8'h40);
    rd_chk("ready gated", `OFS_READY, 8'h21);
    i_host_bus_model.wr_reg(`OFS_MODEM, 8'hc0);
    settle();
    `CHK("prescale four", 1'b1, cfg.prescale_four)
    i_host_bus_model.wr_reg(`OFS_MODEM, 8'hc0 & 8'h7f);
    settle();
    `CHK("prescale one", 1'b0, cfg.prescale_four)
    i_host_bus_model.restore_ext();
    settle();
    `CHK("feature back", 8'h0f, cfg.feature)
    rd_chk("line back", `OFS_LINE, 8'h00);
    conclude();
  end
endmodule // uart_ext_regs_tb
